// ### design/lfm_top.sv
// lfm_top: fault management of an eight-channel LED string driver with APB registers.
// assumes comparator results, enable, control inputs and lockout are synchronous to I_REF_CLK.
// Functional notes
// R1 - on error, gate off and isolate channel first, then start fault signalling
// R2 - fault output toggles at about 80 kHz while a fault is reported
// R3 - low duty 25/50/75/100 percent for led open, led short, fet open, fet short
// R4 - over-temperature: all channels and regulator off, output low, latched
// R5 - led open, led short, fet open checked only while on, latched
// R6 - wait 13 us after channel turn-on before sampling comparators
// R7 - abnormal state must persist 13 us before declaring an error
// R8 - latched faults clear on enable high-low-high or undervoltage reset
// R9 - fet short not latched, released once source below 0.7 V
// R10 - led open when drain below 0.8 V on an on channel
// R11 - led short above 19.2 V in 2ch mode, else eight times reference
// R12 - fet open below quarter dim level under 1.4 V, else below 0.3 V
// R13 - fet short monitored continuously, flagged above 0.9 V
// R14 - supply below 7.0 V holds everything in standby and reset; the fet short flags and the APB registers are not reset by it
// R15 - enable high lets control inputs drive channels, low disables all
// R16 - 4ch mode with control 2 high voltage, 8ch with controls 2 and 4
// R17 - several classes active: report the one with the highest duty
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module lfm_top (
	input  wire logic                I_REF_CLK,
	input  wire logic                I_RST_N,
	input  wire logic                I_ENABLE,
	input  wire logic [3:0]          I_PWM_CONTROL_INPUT,
	input  wire logic                I_CTRL2_HV,
	input  wire logic                I_CTRL4_HV,
	input  wire logic                I_UNDERVOLTAGE_LOCKOUT,
	input  wire logic                I_OVER_TEMPERATURE,
	input  wire logic                I_ANALOG_DIM_LEVEL_HI,
	input  wire lfm_pkg::lfm_sense_t I_SENSE,
	input  wire logic                I_FAULT_INDICATOR_IN,
	output logic                     O_FAULT_INDICATOR_OUT,
	output logic                     O_FAULT_INDICATOR_OE,
	output logic [7:0]               O_GATE,
	output logic                     O_REG_EN,
	input  wire logic                I_PSEL,
	input  wire logic                I_PENABLE,
	input  wire logic                I_PWRITE,
	input  wire logic [11:0]         I_PADDR,
	input  wire logic [31:0]         I_PWDATA,
	output logic [31:0]              O_PRDATA,
	output logic                     O_PREADY,
	output logic                     O_PSLVERR,
	output logic                     O_IRQ
);
	logic                  en_q;
	logic                  clr;
	logic                  ot_q;
	logic                  reg_q;
	lfm_pkg::lfm_mode_t    mode_q;
	lfm_pkg::lfm_cls_t     cls_d;
	lfm_pkg::lfm_cls_t     cls_q;
	logic [7:0]            on;
	logic [7:0]            led_open_v;
	logic [7:0]            led_short_v;
	logic [7:0]            fet_open_v;
	logic [7:0]            fs_v;
	logic [lfm_pkg::IRQ_W-1:0] ev;
	logic [lfm_pkg::IRQ_W-1:0] ev_q;
	logic [lfm_pkg::IRQ_W-1:0] stat_q;
	logic [lfm_pkg::IRQ_W-1:0] mask_q;
	logic [lfm_pkg::IRQ_W-1:0] w1c;
	logic                  wr;
	logic                  rd_setup;
	logic                  mapped;
	logic [31:0]           rdata;
	logic                  drive;

	// any enable rising edge follows a low phase, so it completes the toggle
	assign clr = I_UNDERVOLTAGE_LOCKOUT || (I_ENABLE && !en_q); // [R8] [R14]

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			en_q <= 1'b0;
		else
			en_q <= I_ENABLE;
	end

	// cause still present keeps the latch set through a toggle
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			ot_q <= 1'b0;
		else
			ot_q <= I_OVER_TEMPERATURE || (ot_q && !clr); // [R4]
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			reg_q <= 1'b0;
		else
			reg_q <= !ot_q && !I_UNDERVOLTAGE_LOCKOUT; // [R4] [R14]
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			mode_q <= lfm_pkg::MODE_2CH;
		else if (I_CTRL2_HV && I_CTRL4_HV)
			mode_q <= lfm_pkg::MODE_8CH; // [R16]
		else if (I_CTRL2_HV)
			mode_q <= lfm_pkg::MODE_4CH;
		else
			mode_q <= lfm_pkg::MODE_2CH;
	end

	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_ch
			localparam int C2 = i / 2;
			localparam int C4 = ((i / 2) % 2) * 2;
			logic              req;
			logic [2:0]        lat;
			lfm_pkg::lfm_chk_t chk;

			always_comb
			begin
				case (mode_q)
					lfm_pkg::MODE_4CH: req = I_PWM_CONTROL_INPUT[C4];
					lfm_pkg::MODE_8CH: req = I_PWM_CONTROL_INPUT[0];
					default:           req = I_PWM_CONTROL_INPUT[C2];
				endcase
			end

			// standby and over-temperature override the control inputs
			assign on[i] = I_ENABLE && req && !ot_q && !I_UNDERVOLTAGE_LOCKOUT; // [R15] [R4]

			assign chk.led_open = I_SENSE.drain_lo[i]; // [R10]
			assign chk.led_short = (mode_q == lfm_pkg::MODE_2CH) ? I_SENSE.drain_hi_fix[i]
				: I_SENSE.drain_hi_ref[i]; // [R11]
			assign chk.fet_open = I_ANALOG_DIM_LEVEL_HI ? I_SENSE.src_lo_fix[i]
				: I_SENSE.src_lo_dim[i]; // [R12]
			assign chk.fshort = I_SENSE.src_hi[i]; // [R13]
			assign chk.fsclr  = I_SENSE.src_clr[i];

			lfm_chan u_chan (
				.i_clk   (I_REF_CLK),
				.i_rst_n (I_RST_N),
				.i_on    (on[i]),
				.i_clr   (clr),
				.i_chk   (chk),
				.o_gate  (O_GATE[i]),
				.o_lat   (lat),
				.o_fs    (fs_v[i])
			);

			assign led_open_v[i]  = lat[lfm_pkg::F_LED_OPEN];
			assign led_short_v[i] = lat[lfm_pkg::F_LED_SHORT];
			assign fet_open_v[i]  = lat[lfm_pkg::F_FET_OPEN];
		end
	endgenerate

	always_comb
	begin
		if (ot_q || (|fs_v))
			cls_d = lfm_pkg::CLS_FET_SHORT; // [R17] [R4]
		else if (|fet_open_v)
			cls_d = lfm_pkg::CLS_FET_OPEN;
		else if (|led_short_v)
			cls_d = lfm_pkg::CLS_LED_SHORT;
		else if (|led_open_v)
			cls_d = lfm_pkg::CLS_LED_OPEN;
		else
			cls_d = lfm_pkg::CLS_NONE;
	end

	// one stage after the latch, so the gate is already off when signalling starts
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			cls_q <= lfm_pkg::CLS_NONE;
		else
			cls_q <= cls_d; // [R1]
	end

	lfm_flt u_flt (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RST_N),
		.i_cls   (cls_q),
		.o_drive (drive)
	);

	// open drain: only ever pulls low
	assign O_FAULT_INDICATOR_OUT = 1'b0;
	assign O_FAULT_INDICATOR_OE  = drive; // [R2] [R3]
	assign O_REG_EN              = reg_q;

	assign ev = {ot_q, |fs_v, |fet_open_v, |led_short_v, |led_open_v};

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			ev_q <= '0;
		else
			ev_q <= ev;
	end

	assign wr       = I_PSEL && I_PENABLE && I_PWRITE;
	assign rd_setup = I_PSEL && !I_PENABLE && !I_PWRITE;
	assign mapped   = (I_PADDR == lfm_pkg::OFF_IRQ_STAT) || (I_PADDR == lfm_pkg::OFF_IRQ_MASK)
		|| (I_PADDR == lfm_pkg::OFF_CH_FAULT) || (I_PADDR == lfm_pkg::OFF_STATE);
	assign w1c      = (wr && I_PADDR == lfm_pkg::OFF_IRQ_STAT) ? I_PWDATA[lfm_pkg::IRQ_W-1:0]
		: '0;

	// a new event in the clearing cycle stays set
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			stat_q <= '0;
		else
			stat_q <= (stat_q & ~w1c) | (ev & ~ev_q);
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			mask_q <= lfm_pkg::MASK_RST;
		else if (wr && I_PADDR == lfm_pkg::OFF_IRQ_MASK)
			mask_q <= I_PWDATA[lfm_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			O_IRQ <= 1'b0;
		else
			O_IRQ <= |(stat_q & mask_q);
	end

	always_comb
	begin
		rdata = 32'h00000000;
		if (I_PADDR == lfm_pkg::OFF_IRQ_STAT)
			rdata[lfm_pkg::IRQ_W-1:0] = stat_q;
		else if (I_PADDR == lfm_pkg::OFF_IRQ_MASK)
			rdata[lfm_pkg::IRQ_W-1:0] = mask_q;
		else if (I_PADDR == lfm_pkg::OFF_CH_FAULT)
			rdata = {fs_v, fet_open_v, led_short_v, led_open_v};
		else if (I_PADDR == lfm_pkg::OFF_STATE)
		begin
			rdata[7:0]                    = O_GATE;
			rdata[lfm_pkg::ST_MODE +: 2]  = mode_q;
			rdata[lfm_pkg::ST_OT]         = ot_q;
			rdata[lfm_pkg::ST_CLS +: 3]   = cls_q;
			rdata[lfm_pkg::ST_PIN]        = I_FAULT_INDICATOR_IN;
			rdata[lfm_pkg::ST_REG]        = reg_q;
		end
	end

	// read data captured in the setup phase, ready in the access phase
	always_ff @(posedge I_REF_CLK)
	begin
		if (!I_RST_N)
			O_PRDATA <= 32'h00000000;
		else if (rd_setup)
			O_PRDATA <= rdata;
	end

	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	AST_OT_SHUT: assert property (ot_q |=> O_GATE == 8'h00 && !O_REG_EN) // [R4]
		else $error("over-temperature left a channel or regulator on");
	AST_OT_HOLD: assert property (ot_q && !clr |=> ot_q) // [R4]
		else $error("over-temperature latch lost");
	AST_OT_LOW: assert property (ot_q [*3] |-> O_FAULT_INDICATOR_OE) // [R4]
		else $error("fault line not low in over-temperature");
	AST_EN_OFF: assert property (!I_ENABLE |=> O_GATE == 8'h00) // [R15]
		else $error("channel on with enable low");
	AST_UV_CLR: assert property (I_UNDERVOLTAGE_LOCKOUT |=> // [R14]
		(led_open_v | led_short_v | fet_open_v) == 8'h00 && O_GATE == 8'h00)
		else $error("lockout not reset");
	AST_MODE: assert property (I_CTRL2_HV && I_CTRL4_HV |=> mode_q == lfm_pkg::MODE_8CH) // [R16]
		else $error("eight channel mode not selected");
	AST_PRIO: assert property ((|fet_open_v) && !ot_q && !(|fs_v) |=> // [R17]
		cls_q == lfm_pkg::CLS_FET_OPEN) else $error("wrong fault class priority");
	AST_TOGGLE: assert property (!I_ENABLE ##1 I_ENABLE && !I_UNDERVOLTAGE_LOCKOUT // [R8]
		|=> (led_open_v | led_short_v | fet_open_v) == 8'h00)
		else $error("enable toggle did not clear");
endmodule // lfm_top

// ### design/lfm_pkg.sv
// lfm_pkg: constants, register map and carrier types of the channel fault monitor.
// assumes a 250 MHz reference clock and digital comparator results from the analog front end.
package lfm_pkg;
	localparam int CLK_NS = 4;
	localparam int CW     = 12;
	// detection settle and error confirmation, least times
	localparam int DET_NS  = 13000;
	localparam int DET_CYC = (DET_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [CW-1:0] DET_CNT = CW'(DET_CYC);
	// fault waveform rate
	localparam int FLT_HZ  = 80000;
	localparam int PER_CYC = 1000000000 / (FLT_HZ * CLK_NS);
	localparam logic [CW-1:0] PER_CNT = CW'(PER_CYC);
	localparam logic [CW-1:0] Q1_CNT  = CW'(PER_CYC / 4);
	localparam logic [CW-1:0] Q2_CNT  = CW'(PER_CYC / 2);
	localparam logic [CW-1:0] Q3_CNT  = CW'((PER_CYC * 3) / 4);
	// register map, byte addresses
	localparam logic [11:0] OFF_IRQ_STAT = 12'h000;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h004;
	localparam logic [11:0] OFF_CH_FAULT = 12'h008;
	localparam logic [11:0] OFF_STATE    = 12'h00C;
	localparam int          IRQ_W        = 5;
	localparam logic [4:0]  MASK_RST     = 5'h00;
	// state register fields
	localparam int ST_MODE = 8;
	localparam int ST_OT   = 10;
	localparam int ST_CLS  = 11;
	localparam int ST_PIN  = 14;
	localparam int ST_REG  = 15;
	// latched fault vector positions
	localparam int F_LED_OPEN  = 0;
	localparam int F_LED_SHORT = 1;
	localparam int F_FET_OPEN  = 2;

	// ordered so that a larger value is a longer low duty
	typedef enum logic [2:0] {
		CLS_NONE,
		CLS_LED_OPEN,
		CLS_LED_SHORT,
		CLS_FET_OPEN,
		CLS_FET_SHORT
	} lfm_cls_t;
	typedef enum logic [1:0] {MODE_2CH, MODE_4CH, MODE_8CH} lfm_mode_t;

	// comparator results, one bit per channel
	typedef struct packed {
		logic [7:0] drain_lo;
		logic [7:0] drain_hi_fix;
		logic [7:0] drain_hi_ref;
		logic [7:0] src_lo_dim;
		logic [7:0] src_lo_fix;
		logic [7:0] src_hi;
		logic [7:0] src_clr;
	} lfm_sense_t;

	// qualified causes for one channel
	typedef struct packed {
		logic led_open;
		logic led_short;
		logic fet_open;
		logic fshort;
		logic fsclr;
	} lfm_chk_t;
endpackage

// ### design/lfm_chan.sv
// lfm_chan: settle/confirm timers, fault latches and gate drive of one channel.
// assumes causes are already selected for the feedback mode and dimming level.
`timescale 1ns/100ps
module lfm_chan (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_on,
	input  wire logic              i_clr,
	input  wire lfm_pkg::lfm_chk_t i_chk,
	output logic                   o_gate,
	output logic [2:0]             o_lat,
	output logic                   o_fs
);
	logic [lfm_pkg::CW-1:0] set_q;
	logic [lfm_pkg::CW-1:0] cnf_q;
	logic [2:0]             lat_q;
	logic [2:0]             lat_d;
	logic [2:0]             cause;
	logic                   armed;
	logic                   hit;
	logic                   fs_q;

	assign cause = {i_chk.fet_open, i_chk.led_short, i_chk.led_open};
	assign armed = i_on && (set_q == lfm_pkg::DET_CNT);
	assign hit   = armed && (|cause) && (cnf_q == lfm_pkg::DET_CNT) && !(|lat_q);
	// a new cause wins over a clear in the same cycle
	assign lat_d = (i_clr ? 3'h0 : lat_q) | (hit ? cause : 3'h0); // [R5] [R8]

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !i_on)
			set_q <= '0;
		else if (set_q != lfm_pkg::DET_CNT)
			set_q <= set_q + 1'b1; // [R6]
	end

	// abnormal state must persist unbroken; any gap restarts the count
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !armed || !(|cause) || (|lat_q))
			cnf_q <= '0;
		else if (cnf_q != lfm_pkg::DET_CNT)
			cnf_q <= cnf_q + 1'b1; // [R7]
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			lat_q <= 3'h0;
		else
			lat_q <= lat_d;
	end

	// gate drops at the same edge the latch sets, ahead of any indication
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_gate <= 1'b0;
		else
			o_gate <= i_on && !(|lat_d); // [R1]
	end

	// not latched: hysteresis between the high and the release comparator
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			fs_q <= 1'b0;
		else if (i_chk.fshort)
			fs_q <= 1'b1; // [R13]
		else if (i_chk.fsclr)
			fs_q <= 1'b0; // [R9]
	end

	assign o_lat = lat_q;
	assign o_fs  = fs_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_LATCH_CAUSE: assert property ($rose(|lat_q) |-> $past(cnf_q) == lfm_pkg::DET_CNT // [R7]
		&& $past(i_on)) else $error("fault latched without full confirmation");
	AST_SETTLE: assert property (cnf_q != '0 |-> set_q == lfm_pkg::DET_CNT) // [R6]
		else $error("confirmation started before settle time");
	AST_ON_ONLY: assert property (!i_on |=> !$rose(|lat_q)) // [R5]
		else $error("fault latched while channel off");
	AST_GATE_OFF: assert property (|lat_q |-> !o_gate) // [R1]
		else $error("gate driven with a latched fault");
	AST_FS_SET: assert property (i_chk.fshort |=> fs_q) // [R13]
		else $error("fet short not flagged");
	AST_FS_REL: assert property ($fell(fs_q) |-> $past(i_chk.fsclr)) // [R9]
		else $error("fet short withdrawn without release");
endmodule // lfm_chan

// ### design/lfm_flt.sv
// lfm_flt: open-drain fault waveform, fixed period, low time set by fault class.
// assumes the class input is already prioritised and registered.
`timescale 1ns/100ps
module lfm_flt (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire lfm_pkg::lfm_cls_t i_cls,
	output logic                   o_drive
);
	logic [lfm_pkg::CW-1:0] cnt_q;
	logic                   low;

	// free running so a class change never stretches a period
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || cnt_q == lfm_pkg::PER_CNT - 1'b1)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1; // [R2]
	end

	always_comb
	begin
		case (i_cls)
			lfm_pkg::CLS_LED_OPEN:  low = cnt_q < lfm_pkg::Q1_CNT; // [R3]
			lfm_pkg::CLS_LED_SHORT: low = cnt_q < lfm_pkg::Q2_CNT;
			lfm_pkg::CLS_FET_OPEN:  low = cnt_q < lfm_pkg::Q3_CNT;
			lfm_pkg::CLS_FET_SHORT: low = 1'b1;
			default:                low = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_drive <= 1'b0;
		else
			o_drive <= low;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_WRAP: assert property (cnt_q == lfm_pkg::PER_CNT - 1'b1 |=> cnt_q == '0) // [R2]
		else $error("fault waveform period wrong");
	AST_FULL: assert property (i_cls == lfm_pkg::CLS_FET_SHORT |=> o_drive) // [R3]
		else $error("full duty class not held low");
	AST_QUARTER: assert property (o_drive && $past(i_cls) == lfm_pkg::CLS_LED_OPEN // [R3]
		|-> $past(cnt_q) < lfm_pkg::Q1_CNT) else $error("led open low time too long");
	AST_IDLE: assert property (i_cls == lfm_pkg::CLS_NONE |=> !o_drive) // [R2]
		else $error("fault line driven without a fault");
endmodule // lfm_flt

// ### sim/lfm_plant.sv
// lfm_plant: behavioural FETs, LED strings and the pulled-up fault wire around the monitor.
// assumes the bench injects faults, one bit per channel, and turns them into comparator bits.
`timescale 1ns/100ps
module lfm_plant (
	input  wire logic           i_oe,
	input  wire logic [7:0]     i_open,
	input  wire logic [7:0]     i_short,
	input  wire logic [7:0]     i_fopen,
	input  wire logic [7:0]     i_fshort,
	output lfm_pkg::lfm_sense_t o_sense,
	output logic                o_wire
);
	assign o_sense.drain_lo = i_open;
	assign o_sense.drain_hi_fix = i_short;
	assign o_sense.drain_hi_ref = i_short;
	// a dead fet leaves the source low whatever the dim level, so both comparators trip
	assign o_sense.src_lo_dim = i_fopen;
	assign o_sense.src_lo_fix = i_fopen;
	assign o_sense.src_hi = i_fshort;
	assign o_sense.src_clr = ~i_fshort;
	// pull-up wins whenever the monitor lets go
	assign o_wire = i_oe ? 1'b0 : 1'b1;
endmodule // lfm_plant

// ### sim/lfm_top_tb_top.sv
// lfm_top_tb_top: self-checking bench for the channel fault monitor.
// assumes lfm_plant stands for the fets, strings and fault wire; apb master is this bench.
`timescale 1ns/100ps
module lfm_top_tb_top;
	logic                clk = 1'b0;
	logic                rst_n, en, hv2, hv4, lockout, ot, dimhi, psel, pen, pwr, er;
	logic [3:0]          ctrl;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic                pready, pslverr, irq, fo, oe, regen, fwire;
	logic [7:0]          gate;
	logic [7:0]          inj [4];
	lfm_pkg::lfm_sense_t sense;
	int                  error_cnt = 0;
	int                  compares = 0;
	int                  duty [4];

	always #2 clk = ~clk;

	lfm_top dut_u (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ENABLE(en),
		.I_PWM_CONTROL_INPUT(ctrl), .I_CTRL2_HV(hv2), .I_CTRL4_HV(hv4),
		.I_UNDERVOLTAGE_LOCKOUT(lockout), .I_OVER_TEMPERATURE(ot), .I_ANALOG_DIM_LEVEL_HI(dimhi),
		.I_SENSE(sense), .I_FAULT_INDICATOR_IN(fwire), .O_FAULT_INDICATOR_OUT(fo),
		.O_FAULT_INDICATOR_OE(oe), .O_GATE(gate), .O_REG_EN(regen), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq));
	lfm_plant plant_u (.i_oe(oe), .i_open(inj[0]), .i_short(inj[1]), .i_fopen(inj[2]),
		.i_fshort(inj[3]), .o_sense(sense), .o_wire(fwire));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic report_and_stop;
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one transfer; entered just after a rising edge, leaves one idle cycle behind it
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	// one waveform period sees the whole low time once, whatever the phase
	task automatic meas(input int hi_exp, input int rise_exp);
		int hi, rs;
		logic p;
		hi = 0;
		rs = 0;
		p = oe;
		repeat (lfm_pkg::PER_CYC)
		begin
			@(posedge clk);
			hi += int'(oe === 1'b1);
			rs += int'(oe === 1'b1 && p !== 1'b1);
			p = oe;
		end
		chk("low_time", hi_exp, hi);
		chk("toggles", rise_exp, rs);
	endtask

	function automatic logic [7:0] mgate(input logic [3:0] c);
		logic [7:0] g;
		if (hv2 && hv4)
			g = {8{c[0]}};
		else if (hv2)
			g = {c[2], c[2], c[0], c[0], c[2], c[2], c[0], c[0]};
		else
			g = {c[3], c[3], c[2], c[2], c[1], c[1], c[0], c[0]};
		return (en && !ot && !lockout) ? g : 8'h00;
	endfunction

	task automatic lat_run(input int k, input int ch);
		int n;
		n = 0;
		{hv2, hv4, ctrl, en} <= 7'h01;
		dimhi <= 1'($urandom);
		inj[k][ch] <= 1'b1;
		@(posedge clk);
		if (k == 0)
		begin
			repeat (7000) @(posedge clk);
			chk("idle_fault", 32'h0, {31'h0, oe});
		end
		ctrl <= 4'h1 << (ch / 2);
		repeat (2) @(posedge clk);
		chk("gate_on", {24'h0, mgate(ctrl)}, {24'h0, gate});
		while (gate[ch] !== 1'b0 && n < 8000)
		begin
			@(posedge clk);
			n++;
		end
		chk("qualify", 1, n >= 2 * lfm_pkg::DET_CYC - 2 && n <= 2 * lfm_pkg::DET_CYC + 4);
		chk("first_off", 32'h2, {30'h0, gate[ch ^ 1], oe});
		repeat (4) @(posedge clk);
		meas(duty[k], 1);
		apb(1'b0, lfm_pkg::OFF_CH_FAULT, 32'h0);
		chk("ch_fault", 32'h1 << (8 * k + ch), rd);
		inj[k][ch] <= 1'b0;
		if (k == 0)
		begin
			inj[3][7] <= 1'b1;
			repeat (4) @(posedge clk);
			meas(lfm_pkg::PER_CYC, 0);
			inj[3][7] <= 1'b0;
			repeat (4) @(posedge clk);
			meas(duty[0], 1);
		end
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(1'b1, lfm_pkg::OFF_IRQ_MASK, 32'h1F);
		@(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b0, lfm_pkg::OFF_IRQ_STAT, 32'h0);
		chk("irq_stat", (32'h1 << k) | (k == 0 ? 32'h8 : 32'h0), rd);
		apb(1'b1, lfm_pkg::OFF_IRQ_STAT, 32'h1F);
		@(posedge clk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		apb(1'b1, lfm_pkg::OFF_IRQ_MASK, 32'h0);
		apb(1'b0, lfm_pkg::OFF_CH_FAULT, 32'h0);
		chk("held", 32'h1 << (8 * k + ch), rd);
		en <= 1'b0;
		repeat (2) @(posedge clk);
		chk("en_low", 32'h0, {24'h0, gate});
		en <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, lfm_pkg::OFF_CH_FAULT, 32'h0);
		chk("cleared", 32'h0, {rd[31:1], rd[0] | oe});
	endtask

	initial
	begin
		logic b;
		{rst_n, en, hv2, hv4, lockout, ot, dimhi, psel, pen, pwr, ctrl} = 14'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		inj = '{default: 8'h00};
		duty = '{lfm_pkg::PER_CYC / 4, lfm_pkg::PER_CYC / 2, lfm_pkg::PER_CYC * 3 / 4, lfm_pkg::PER_CYC};
		void'($urandom(32'h1341));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("reg_en", 32'h1, {31'h0, regen});
		apb(1'b0, lfm_pkg::OFF_IRQ_MASK, 32'h0);
		chk("mask_rst", 32'h0, rd);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h1, {rd[31:1], rd[0] | er});
		repeat (30)
		begin
			b = 1'($urandom);
			en <= 1'($urandom);
			ctrl <= 4'($urandom);
			hv2 <= b;
			hv4 <= b & 1'($urandom);
			repeat (3) @(posedge clk);
			chk("gate_map", {24'h0, mgate(ctrl)}, {24'h0, gate});
		end
		lat_run(0, 0);
		lat_run(1, 3);
		lat_run(2, 5);
		ctrl <= 4'hF;
		repeat (3) @(posedge clk);
		chk("gate_all", 32'hFF, {24'h0, gate});
		ot <= 1'b1;
		repeat (3) @(posedge clk);
		chk("ot_off", 32'h0, {23'h0, regen, gate});
		ot <= 1'b0;
		repeat (4) @(posedge clk);
		meas(lfm_pkg::PER_CYC, 0);
		chk("ot_held", 32'h0, {23'h0, regen, gate});
		chk("fault_out", 32'h0, {31'h0, fo});
		apb(1'b0, lfm_pkg::OFF_STATE, 32'h0);
		chk("state", (32'h1 << lfm_pkg::ST_OT) | (32'h4 << lfm_pkg::ST_CLS), rd);
		en <= 1'b0;
		@(posedge clk);
		en <= 1'b1;
		repeat (4) @(posedge clk);
		chk("ot_clr", 32'h1FF, {22'h0, oe, regen, gate});
		ot <= 1'b1;
		repeat (3) @(posedge clk);
		ot <= 1'b0;
		lockout <= 1'b1;
		repeat (3) @(posedge clk);
		chk("lockout", 32'h0, {24'h0, gate});
		lockout <= 1'b0;
		repeat (4) @(posedge clk);
		chk("lockout_clr", 32'h1FF, {22'h0, oe, regen, gate});
		report_and_stop();
	end

	// the full sequence needs about 50000 cycles
	initial
	begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule // lfm_top_tb_top
